// [hdl/tcpwm_pkg.sv]
/*
 * constants, register map and enumerations shared by the timer/counter/pwm unit.
 * assumes a 32-bit apb slave at word-aligned byte offsets.
 */
package tcpwm_pkg;

   // ************************************************************
   // register map (byte offsets)
   // ************************************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] PERIOD_OFS = 8'h04;
   localparam logic [7:0] COMPARE_OFS = 8'h08;
   localparam logic [7:0] COUNT_OFS = 8'h0C;
   localparam logic [7:0] CAPTURE_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   localparam logic [7:0] MASK_OFS = 8'h18;
   localparam logic [7:0] DEADBAND_OFS = 8'h1C;

   // ************************************************************
   // control fields
   // ************************************************************
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_CMP_LSB = 3;
   localparam int CTRL_CLK_LSB = 6;
   localparam int CTRL_CLK_W = 2;
   localparam int CTRL_DIV_LSB = 8;
   localparam int CTRL_DIV_W = 8;

   localparam int STAT_TC_BIT = 0;
   localparam int STAT_CMP_BIT = 1;
   localparam int STAT_CAP_BIT = 2;
   localparam int STAT_W = 3;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
   localparam logic [15:0] COMPARE_RESET = 16'h8000;
   localparam logic [7:0] DEADBAND_RESET = 8'h00;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [7:0] DIV_ONE = 8'h01;
   localparam logic [7:0] DB_ONE = 8'h01;

   typedef enum logic [1:0] {MODE_FREE, MODE_ONESHOT, MODE_GATED, MODE_RSVD} run_mode_t;
   typedef enum logic [2:0] {CMP_LT, CMP_LE, CMP_EQ, CMP_GE, CMP_GT} cmp_mode_t;
   typedef enum logic [1:0] {CLK_CORE, CLK_DIV, CLK_EXT_RISE, CLK_EXT_FALL} clk_sel_t;

endpackage

// [hdl/tcpwm_sync.sv]
/*
 * three-stage synchroniser for one asynchronous input; reports a change only
 * once the second and third stages agree.
 * assumes the core clock; the first stage is read by the second only.
 */
`timescale 1ns/10ps
module tcpwm_sync
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_async,
   output logic o_level,
   output logic o_rise,
   output logic o_fall
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         o_level <= 1'b0;
      end
      else
      begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
         begin
            o_level <= s3_q;
         end
      end
   end

   assign o_rise = (s2_q == s3_q) && s3_q && !o_level;
   assign o_fall = (s2_q == s3_q) && !s3_q && o_level;
endmodule

// [hdl/tcpwm_top.sv]
/*
 * 16-bit down-counting timer/counter/pwm with capture, kill, deadband
 * complementary outputs and masked interrupt, configured over apb.
 * assumes routed inputs are asynchronous to the core clock and go through
 * three flip-flop synchronisers; firmware is a plain apb master.
 */
// Function
// R1: counter is 16 bits and only counts down
// R2: compare true uses lt, le, eq, ge or gt relation
// R3: period loads on start, on reset input, and at terminal count
// R4: interrupt may come from terminal count, compare true or capture
// R5: one-shot runs one period and then stops
// R6: gated mode decrements only while enable input is high
// R7: capture input stores the full 16-bit count in a readable register
// R8: kill input disables the compare outputs while active
// R9: drives compare, terminal count, complementary compare and interrupt outputs
// R10: complementary pwm pair with deadband between edges
// R11: counter clock chosen from several sources by configuration
// R12: terminal count at zero pulses the output for one counter tick; o_tc is high for one core clock cycle instead
// R13: programmable deadband ticks hold both outputs off; kill forces both off
`timescale 1ns/10ps
module tcpwm_top
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_cnt_reset,
   input wire logic i_capture,
   input wire logic i_enable,
   input wire logic i_kill,
   input wire logic i_ext_clk,
   output logic o_cmp,
   output logic o_cmp_n,
   output logic o_tc,
   output logic o_irq
);
   import tcpwm_pkg::*;

   // ************************************************************
   // input synchronisers
   // ************************************************************
   logic rst_lvl;
   logic rst_rise;
   logic cap_rise;
   logic en_lvl;
   logic kill_lvl;
   logic ext_rise;
   logic ext_fall;

   tcpwm_sync u_sync_rst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_async(i_cnt_reset),
      .o_level(rst_lvl), .o_rise(rst_rise), .o_fall());
   tcpwm_sync u_sync_cap (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_async(i_capture),
      .o_level(), .o_rise(cap_rise), .o_fall());
   tcpwm_sync u_sync_en (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_async(i_enable),
      .o_level(en_lvl), .o_rise(), .o_fall());
   tcpwm_sync u_sync_kill (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_async(i_kill),
      .o_level(kill_lvl), .o_rise(), .o_fall());
   tcpwm_sync u_sync_ext (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_async(i_ext_clk),
      .o_level(), .o_rise(ext_rise), .o_fall(ext_fall));

   // ************************************************************
   // registers
   // ************************************************************
   logic [31:0] ctrl_q;
   logic [15:0] period_q;
   logic [15:0] compare_q;
   logic [15:0] count_q;
   logic [15:0] capture_q;
   logic [STAT_W-1:0] status_q;
   logic [STAT_W-1:0] mask_q;
   logic [7:0] deadband_q;

   logic run_en;
   run_mode_t run_mode;
   cmp_mode_t cmp_mode;
   clk_sel_t clk_sel;
   logic [7:0] div_val;

   assign run_en = ctrl_q[CTRL_RUN_BIT];
   assign run_mode = run_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
   assign cmp_mode = cmp_mode_t'(ctrl_q[CTRL_CMP_LSB +: 3]);
   assign clk_sel = clk_sel_t'(ctrl_q[CTRL_CLK_LSB +: CTRL_CLK_W]);
   assign div_val = ctrl_q[CTRL_DIV_LSB +: CTRL_DIV_W];

   logic wr_acc;
   logic rd_acc;
   assign wr_acc = i_psel && i_penable && i_pwrite;
   assign rd_acc = i_psel && i_penable && !i_pwrite;

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ctrl_q <= CTRL_RESET;
         period_q <= PERIOD_RESET;
         compare_q <= COMPARE_RESET;
         mask_q <= '0;
         deadband_q <= DEADBAND_RESET;
      end
      else if (wr_acc)
      begin
         unique case (i_paddr)
            CTRL_OFS: ctrl_q <= i_pwdata;
            PERIOD_OFS: period_q <= i_pwdata[15:0];
            COMPARE_OFS: compare_q <= i_pwdata[15:0];
            MASK_OFS: mask_q <= i_pwdata[STAT_W-1:0];
            DEADBAND_OFS: deadband_q <= i_pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ************************************************************
   // counter clock source
   // ************************************************************
   logic [7:0] div_cnt_q;
   logic tick;

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         div_cnt_q <= '0;
      end
      else if (div_cnt_q + DIV_ONE >= div_val)
      begin
         div_cnt_q <= '0;
      end
      else
      begin
         div_cnt_q <= div_cnt_q + DIV_ONE;
      end
   end

   always_comb
   begin
      unique case (clk_sel) // R11
         CLK_CORE: tick = 1'b1;
         CLK_DIV: tick = (div_cnt_q + DIV_ONE >= div_val);
         CLK_EXT_RISE: tick = ext_rise;
         CLK_EXT_FALL: tick = ext_fall;
      endcase
   end

   // ************************************************************
   // counter
   // ************************************************************
   logic run_d1_q;
   logic stopped_q;
   logic start;
   logic count_step;
   logic at_tc;

   assign start = run_en && !run_d1_q;
   assign at_tc = (count_q == CNT_ZERO);
   // gated mode only steps while enable is held high
   assign count_step = run_en && !stopped_q && tick &&
      (run_mode != MODE_GATED || en_lvl); // R6

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         run_d1_q <= 1'b0;
      end
      else
      begin
         run_d1_q <= run_en;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         count_q <= CNT_ZERO;
         stopped_q <= 1'b0;
      end
      else if (start || rst_rise)
      begin
         count_q <= period_q; // R3
         stopped_q <= 1'b0;
      end
      else if (count_step)
      begin
         if (at_tc)
         begin
            count_q <= period_q; // R3
            stopped_q <= (run_mode == MODE_ONESHOT); // R5
         end
         else
         begin
            count_q <= count_q - CNT_ONE; // R1
         end
      end
   end

   // ************************************************************
   // compare, terminal count, capture
   // ************************************************************
   logic cmp_true;
   always_comb
   begin
      unique case (cmp_mode) // R2
         CMP_LT: cmp_true = count_q < compare_q;
         CMP_LE: cmp_true = count_q <= compare_q;
         CMP_EQ: cmp_true = count_q == compare_q;
         CMP_GE: cmp_true = count_q >= compare_q;
         CMP_GT: cmp_true = count_q > compare_q;
         default: cmp_true = 1'b0;
      endcase
   end

   logic tc_evt;
   logic cmp_q;
   logic cmp_evt;
   assign tc_evt = count_step && at_tc; // R12
   assign cmp_evt = run_en && cmp_true && !cmp_q;

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cmp_q <= 1'b0;
         o_tc <= 1'b0;
      end
      else
      begin
         cmp_q <= run_en && cmp_true;
         o_tc <= tc_evt; // R12
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         capture_q <= CNT_ZERO;
      end
      else if (cap_rise)
      begin
         capture_q <= count_q; // R7
      end
   end

   // ************************************************************
   // deadband and kill
   // ************************************************************
   logic [7:0] db_cnt_q;
   logic last_q;

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_cmp <= 1'b0;
         o_cmp_n <= 1'b0;
         db_cnt_q <= '0;
         last_q <= 1'b0;
      end
      else if (kill_lvl || !run_en)
      begin
         o_cmp <= 1'b0; // R8
         o_cmp_n <= 1'b0; // R13
         db_cnt_q <= deadband_q;
         last_q <= cmp_q;
      end
      else if (cmp_q != last_q)
      begin
         // both off first so the pair never overlaps
         o_cmp <= 1'b0; // R10
         o_cmp_n <= 1'b0;
         db_cnt_q <= deadband_q;
         last_q <= cmp_q;
      end
      else if (db_cnt_q != '0)
      begin
         if (tick)
         begin
            db_cnt_q <= db_cnt_q - DB_ONE; // R13
         end
      end
      else
      begin
         o_cmp <= last_q; // R9
         o_cmp_n <= !last_q;
      end
   end

   // ************************************************************
   // status and interrupt
   // ************************************************************
   logic [STAT_W-1:0] evt;
   logic stat_rd;
   logic [STAT_W-1:0] mask_nxt;
   assign evt = {cap_rise, cmp_evt, tc_evt};
   // the irq flop sees a mask write in the same edge, so it never lags the mask by a cycle
   assign mask_nxt = (wr_acc && (i_paddr == MASK_OFS)) ? i_pwdata[STAT_W-1:0] : mask_q;
   assign stat_rd = rd_acc && (i_paddr == STATUS_OFS);

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         status_q <= '0;
      end
      else
      begin
         // a new event in the clearing read still sets its bit
         status_q <= (stat_rd ? '0 : status_q) | evt; // R4
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_irq <= 1'b0;
      end
      else
      begin
         o_irq <= |(((stat_rd ? '0 : status_q) | evt) & mask_nxt); // R4
      end
   end

   // ************************************************************
   // apb read path, zero wait state
   // ************************************************************
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_prdata <= UNMAPPED_DATA;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready <= 1'b1;
         o_pslverr <= 1'b0;
         if (i_psel && !i_penable && !i_pwrite)
         begin
            unique case (i_paddr)
               CTRL_OFS: o_prdata <= ctrl_q;
               PERIOD_OFS: o_prdata <= {16'h0000, period_q};
               COMPARE_OFS: o_prdata <= {16'h0000, compare_q};
               COUNT_OFS: o_prdata <= {16'h0000, count_q};
               CAPTURE_OFS: o_prdata <= {16'h0000, capture_q};
               STATUS_OFS: o_prdata <= {29'h0000_0000, status_q};
               MASK_OFS: o_prdata <= {29'h0000_0000, mask_q};
               DEADBAND_OFS: o_prdata <= {24'h00_0000, deadband_q};
               default: o_prdata <= UNMAPPED_DATA;
            endcase
         end
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   tc_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R12
      o_tc |=> !o_tc || $past(tc_evt)) else $error("tc pulse not caused by zero");
   down_only_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R1
      $past(count_step) && !$past(at_tc) && !$past(start) && !$past(rst_rise)
      |-> count_q == $past(count_q) - CNT_ONE) else $error("counter did not decrement");
   reload_tc_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R3
      tc_evt && !start && !rst_rise |=> count_q == $past(period_q))
      else $error("no reload at terminal count");
   oneshot_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R5
      tc_evt && run_mode == MODE_ONESHOT && !start && !rst_rise |=> stopped_q)
      else $error("one-shot kept running");
   gated_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R6
      run_mode == MODE_GATED && !en_lvl && !start && !rst_rise |=> $stable(count_q))
      else $error("gated counter moved");
   capture_val_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R7
      cap_rise |=> capture_q == $past(count_q)) else $error("capture value wrong");
   kill_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R8
      kill_lvl |=> !o_cmp && !o_cmp_n) else $error("kill did not disable outputs");
   no_overlap_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R10
      !(o_cmp && o_cmp_n)) else $error("complementary outputs overlap");
   irq_level_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R4
      |(status_q & mask_q) |-> o_irq) else $error("irq low with pending bit");

   tc_seen_c: cover property (@(posedge i_core_clk) disable iff (!i_rstn) tc_evt);
   cap_seen_c: cover property (@(posedge i_core_clk) disable iff (!i_rstn) cap_rise);
   db_gap_c: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
      $fell(o_cmp) ##[1:20] o_cmp_n);
   irq_seen_c: cover property (@(posedge i_core_clk) disable iff (!i_rstn) o_irq);
endmodule

// [verif/tcpwm_route_model.sv]
/*
 * far-side routed logic model: makes the external count clock for the timer.
 * assumes the core clock; the count clock stands low while not enabled.
 */
`timescale 1ns/10ps
module tcpwm_route_model
(
   input wire logic i_core_clk,
   input wire logic i_run,
   output logic o_ext_clk
);
   logic [1:0] div_q;

   // ************************************************************
   // slow clock, three core cycles per half period
   // ************************************************************
   always_ff @(posedge i_core_clk)
   begin
      if (!i_run)
      begin
         div_q <= 2'h0;
         o_ext_clk <= 1'b0;
      end
      else if (div_q == 2'h2)
      begin
         div_q <= 2'h0;
         o_ext_clk <= ~o_ext_clk;
      end
      else
      begin
         div_q <= div_q + 2'h1;
      end
   end
endmodule

// [verif/testbench.sv]
/*
 * self-checking bench for the timer/counter/pwm unit, driven over apb.
 * assumes zero-wait apb and routed inputs seen within eight core cycles.
 */
`timescale 1ns/10ps
module testbench;
   import tcpwm_pkg::*;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic i_core_clk, i_rstn, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
   logic [7:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, v;
   logic i_cnt_reset, i_capture, i_enable, i_kill, ext_clk, ext_run;
   logic o_cmp, o_cmp_n, o_tc, o_irq, e;
   int err_count, tests_run, n;

   tcpwm_top i_tcpwm_top (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_cnt_reset(i_cnt_reset), .i_capture(i_capture), .i_enable(i_enable),
      .i_kill(i_kill), .i_ext_clk(ext_clk), .o_cmp(o_cmp), .o_cmp_n(o_cmp_n),
      .o_tc(o_tc), .o_irq(o_irq));
   tcpwm_route_model i_tcpwm_route_model (.i_core_clk(i_core_clk), .i_run(ext_run),
      .o_ext_clk(ext_clk));

   // ************************************************************
   // checking and bus tasks
   // ************************************************************
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_pin(input string what, input logic exp, input logic got);
      check_val(what, {31'h0, exp}, {31'h0, got});
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge i_core_clk);
      #1;
   endtask

   // request held until the edge that samples pready high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rdat);
      int k;
      @(posedge i_core_clk);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge i_core_clk);
         if (o_pready === 1'b1)
            break;
      end
      rdat = o_prdata;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (k == 50)
      begin
         err_count++;
         summarize();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      apb(1'b1, a, d, dummy);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
      input logic [31:0] m);
      logic [31:0] got;
      apb(1'b0, a, 32'h0000_0000, got);
      check_val(what, exp, got & m);
   endtask

   function automatic logic [31:0] ctl(input logic [1:0] md, input logic [2:0] cm,
      input logic [1:0] cs);
      ctl = 32'h0000_0001 | (32'(md) << CTRL_MODE_LSB) | (32'(cm) << CTRL_CMP_LSB)
         | (32'(cs) << CTRL_CLK_LSB);
   endfunction

   initial
   begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      {i_rstn, i_psel, i_penable, i_pwrite, i_cnt_reset, i_capture} = 6'h00;
      {i_enable, i_kill, ext_run} = 3'h0;
      i_paddr = 8'h00;
      i_pwdata = 32'h0000_0000;
      err_count = 0;
      tests_run = 0;
      repeat (4) @(posedge i_core_clk);
      i_rstn <= 1'b1;
      rd_chk("ctrl", CTRL_OFS, CTRL_RESET, ALL);
      rd_chk("period", PERIOD_OFS, {16'h0000, PERIOD_RESET}, ALL);
      rd_chk("compare", COMPARE_OFS, {16'h0000, COMPARE_RESET}, ALL);
      rd_chk("deadband", DEADBAND_OFS, {24'h00_0000, DEADBAND_RESET}, ALL);
      rd_chk("unmapped", 8'h20, UNMAPPED_DATA, ALL);
      check_pin("slverr", 1'b0, o_pslverr);
      // one-shot: single period, one-cycle terminal pulse, then stop
      wr(PERIOD_OFS, 32'h0000_0005);
      wr(MASK_OFS, 32'h0000_0001);
      wr(CTRL_OFS, ctl(MODE_ONESHOT, CMP_LT, CLK_CORE));
      for (n = 0; n < 50 && o_tc !== 1'b1; n++)
         cyc(1);
      check_pin("tc seen", 1'b1, o_tc);
      cyc(1);
      check_pin("tc width", 1'b0, o_tc);
      cyc(20);
      rd_chk("oneshot stop", COUNT_OFS, 32'h0000_0005, ALL);
      check_pin("irq tc", 1'b1, o_irq);
      rd_chk("status tc", STATUS_OFS, 32'h0000_0001, 32'h0000_0001);
      cyc(2);
      check_pin("irq cleared", 1'b0, o_irq);
      rd_chk("status clear", STATUS_OFS, 32'h0000_0000, 32'h0000_0001);
      // compare relations against the held count of 5
      for (int m = 0; m < 5; m++)
         for (int c = 5; c < 7; c++)
         begin
            wr(COMPARE_OFS, 32'(c));
            wr(CTRL_OFS, ctl(MODE_ONESHOT, 3'(m), CLK_CORE));
            cyc(12);
            e = (m == 0) ? (5 < c) : (m == 1) ? (5 <= c) : (m == 2) ? (5 == c) :
               (m == 3) ? (5 >= c) : (5 > c);
            check_pin("cmp", e, o_cmp);
            check_pin("cmp_n", ~e, o_cmp_n);
         end
      // deadband: both low for four ticks around a rising compare
      wr(DEADBAND_OFS, 32'h0000_0004);
      wr(COMPARE_OFS, 32'h0000_0004);
      n = 0;
      for (int k = 0; k < 40 && o_cmp !== 1'b1; k++)
      begin
         cyc(1);
         if (o_cmp === 1'b0 && o_cmp_n === 1'b0)
            n++;
      end
      check_pin("deadband gap", 1'b1, n >= 4 && n <= 6);
      cyc(1);
      check_pin("pair", 1'b0, o_cmp_n);
      @(posedge i_core_clk);
      i_kill <= 1'b1;
      cyc(8);
      check_pin("kill cmp", 1'b0, o_cmp);
      check_pin("kill cmp_n", 1'b0, o_cmp_n);
      @(posedge i_core_clk);
      i_kill <= 1'b0;
      cyc(20);
      check_pin("unkill", 1'b1, o_cmp);
      // external clock source and reload by the reset input
      wr(CTRL_OFS, 32'h0000_0000);
      wr(PERIOD_OFS, 32'h0000_0100);
      wr(CTRL_OFS, ctl(MODE_FREE, CMP_LT, CLK_EXT_RISE));
      cyc(8);
      rd_chk("ext idle", COUNT_OFS, 32'h0000_0100, ALL);
      @(posedge i_core_clk);
      ext_run <= 1'b1;
      cyc(60);
      @(posedge i_core_clk);
      ext_run <= 1'b0;
      cyc(8);
      apb(1'b0, COUNT_OFS, 32'h0000_0000, v);
      check_pin("ext down", 1'b1, v < 32'h0000_0100 && v > 32'h0000_00E0);
      rd_chk("ext held", COUNT_OFS, v, ALL);
      @(posedge i_core_clk);
      i_cnt_reset <= 1'b1;
      cyc(6);
      @(posedge i_core_clk);
      i_cnt_reset <= 1'b0;
      cyc(8);
      rd_chk("reset reload", COUNT_OFS, 32'h0000_0100, ALL);
      // gated counting and capture
      wr(CTRL_OFS, 32'h0000_0000);
      wr(PERIOD_OFS, 32'h0000_1234);
      wr(MASK_OFS, 32'h0000_0004);
      wr(CTRL_OFS, ctl(MODE_GATED, CMP_EQ, CLK_CORE));
      cyc(8);
      rd_chk("gated hold", COUNT_OFS, 32'h0000_1234, ALL);
      @(posedge i_core_clk);
      i_capture <= 1'b1;
      cyc(6);
      @(posedge i_core_clk);
      i_capture <= 1'b0;
      cyc(8);
      rd_chk("capture", CAPTURE_OFS, 32'h0000_1234, ALL);
      check_pin("irq capture", 1'b1, o_irq);
      rd_chk("status cap", STATUS_OFS, 32'h0000_0004, 32'h0000_0004);
      @(posedge i_core_clk);
      i_enable <= 1'b1;
      cyc(20);
      @(posedge i_core_clk);
      i_enable <= 1'b0;
      cyc(8);
      apb(1'b0, COUNT_OFS, 32'h0000_0000, v);
      check_pin("gated ran", 1'b1, v < 32'h0000_1234 && v > 32'h0000_1200);
      rd_chk("gated stop", COUNT_OFS, v, ALL);
      // divided core clock: one tick every four core cycles
      wr(CTRL_OFS, 32'h0000_0000);
      wr(CTRL_OFS, ctl(MODE_FREE, CMP_LT, CLK_DIV) | 32'h0000_0400);
      cyc(40);
      apb(1'b0, COUNT_OFS, 32'h0000_0000, v);
      check_pin("div rate", 1'b1, v < 32'h0000_1234 && v > 32'h0000_1220);
      // external clock, falling edges
      wr(CTRL_OFS, 32'h0000_0000);
      wr(CTRL_OFS, ctl(MODE_FREE, CMP_LT, CLK_EXT_FALL));
      @(posedge i_core_clk);
      ext_run <= 1'b1;
      cyc(60);
      @(posedge i_core_clk);
      ext_run <= 1'b0;
      cyc(8);
      apb(1'b0, COUNT_OFS, 32'h0000_0000, v);
      check_pin("ext fall", 1'b1, v < 32'h0000_1234 && v > 32'h0000_1220);
      summarize();
   end
endmodule
